// [common/pci_defines.vh]
`ifndef PCI_DEFINES_VH
`define PCI_DEFINES_VH

// Port geometry.
`define PCI_PORT_WIDTH      16
`define PCI_NUM_PORTS       4

// Reset values of the control and status state.
`define PCI_GLOBAL_EN_RST   1'h0
`define PCI_PORT_RST        16'h0000

// Synchroniser depth for pin inputs.
`define PCI_SYNC_STAGES     3

`endif

// [logic/pci_port.v]
`timescale 1ns/1ps
`include "pci_defines.vh"

// One port of pin change detection: sync, edge detect, sticky flags.
module pci_port #(
	parameter WIDTH = `PCI_PORT_WIDTH
)(
	// Clock and reset
	input  wire             ref_clk_in,
	input  wire             rst_b_in,
	// Control
	input  wire             global_en_in,
	input  wire [WIDTH-1:0] rising_edge_enable_in,
	input  wire [WIDTH-1:0] falling_edge_enable_in,
	// Flag clear: a one-cycle strobe with a mask, zero bits clear
	input  wire             flag_wr_in,
	input  wire [WIDTH-1:0] flag_wr_data_in,
	// Pins and state
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_change_flag_out,
	output wire [WIDTH-1:0] pin_state_out
);

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	reg [WIDTH-1:0] stable_q;
	reg [WIDTH-1:0] flag_q;
	reg [WIDTH-1:0] flag_d;
	reg [WIDTH-1:0] stable_d;
	wire [WIDTH-1:0] agree;
	wire [WIDTH-1:0] rise;
	wire [WIDTH-1:0] fall;
	wire [WIDTH-1:0] hit;

	// A change counts once the second and third stages agree, so a
	// metastable first stage never reaches the edge detector.
	assign agree = ~(s2_q ^ s3_q);

	always @*
	begin
		stable_d = (stable_q & ~agree) | (s3_q & agree);
	end

	// ----------------------------------------
	// Edge detection and flags
	// ----------------------------------------
	assign rise = stable_d & ~stable_q;
	assign fall = ~stable_d & stable_q;
	assign hit  = {WIDTH{global_en_in}} &
		((rise & rising_edge_enable_in) | (fall & falling_edge_enable_in));

	always @*
	begin
		flag_d = flag_q;
		if (flag_wr_in)
		begin
			flag_d = flag_q & flag_wr_data_in;
		end
		flag_d = flag_d | hit;
	end

	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s1_q     <= {WIDTH{1'b0}};
			s2_q     <= {WIDTH{1'b0}};
			s3_q     <= {WIDTH{1'b0}};
			stable_q <= {WIDTH{1'b0}};
			flag_q   <= {WIDTH{1'b0}};
		end
		else
		begin
			s1_q     <= pin_in;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
			flag_q   <= flag_d;
		end
	end

	assign pin_change_flag_out = flag_q;
	assign pin_state_out       = stable_q;

endmodule

// [logic/pci_unit.v]
`timescale 1ns/1ps
`include "pci_defines.vh"

// How it works
// - Edges are detected and requests raised; block keeps its clock in sleep.
// - No change request unless the global change-detect enable is set.
// - Rising-edge enable makes each low-to-high transition raise a request.
// - Falling-edge enable makes each high-to-low transition raise a request.
// - Both enables set: each edge raises its own request.
// - A request sets that pin's change flag.
// - A change flag stays set until software writes zero to it.
// - Any set flag in a port sets that port's summary bit.
// - Summary bit clears only when all that port's flags are clear.
// - One write clears every flag written as zero, keeps those written one.
// - An edge in the clearing cycle wins; the flag stays set.
// - Every pin has separately controlled weak pull-up and pull-down.
// - Per-pin pull-up and pull-down enable bits drive the pad pulls.
module pci_unit #(
	parameter WIDTH = `PCI_PORT_WIDTH,
	parameter PORTS = `PCI_NUM_PORTS
)(
	// Clock and reset
	input  wire                   ref_clk_in,
	input  wire                   rst_b_in,
	// Configuration writes, one-cycle strobes with data
	input  wire                   global_en_wr_in,
	input  wire                   global_en_data_in,
	input  wire [PORTS-1:0]       rise_wr_in,
	input  wire [PORTS-1:0]       fall_wr_in,
	input  wire [PORTS-1:0]       pull_up_wr_in,
	input  wire [PORTS-1:0]       pull_down_wr_in,
	input  wire [PORTS-1:0]       flag_wr_in,
	input  wire [WIDTH-1:0]       wr_data_in,
	// Pins
	input  wire [PORTS*WIDTH-1:0] pin_in,
	// Pad controls
	output wire [PORTS*WIDTH-1:0] pull_up_enable_out,
	output wire [PORTS*WIDTH-1:0] pull_down_enable_out,
	// Status
	output wire                   change_detect_global_enable_out,
	output wire [PORTS*WIDTH-1:0] rising_edge_enable_out,
	output wire [PORTS*WIDTH-1:0] falling_edge_enable_out,
	output wire [PORTS*WIDTH-1:0] pin_change_flag_out,
	output wire [PORTS*WIDTH-1:0] pin_state_out,
	output wire [PORTS-1:0]       port_change_summary_out,
	output wire                   pin_change_interrupt_out
);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	reg                   global_en_q;
	reg [PORTS*WIDTH-1:0] rise_q;
	reg [PORTS*WIDTH-1:0] fall_q;
	reg [PORTS*WIDTH-1:0] pu_q;
	reg [PORTS*WIDTH-1:0] pd_q;
	reg [PORTS-1:0]       summary_q;
	reg [PORTS-1:0]       summary_d;
	reg                   irq_q;
	wire [PORTS*WIDTH-1:0] flag_w;
	integer               i;

	// ----------------------------------------
	// Write and status helpers
	// ----------------------------------------
	// Replace one port's slice of a packed vector when its strobe is set.
	function [PORTS*WIDTH-1:0] upd;
		input [PORTS*WIDTH-1:0] cur;
		input [PORTS-1:0]       wr;
		input [WIDTH-1:0]       data;
		integer                 k;
		begin
			upd = cur;
			for (k = 0; k < PORTS; k = k + 1)
			begin
				if (wr[k])
				begin
					upd[k*WIDTH +: WIDTH] = data;
				end
			end
		end
	endfunction

	// True when any flag of the given port is set.
	function port_any;
		input [PORTS*WIDTH-1:0] flags;
		input integer           idx;
		begin
			port_any = |flags[idx*WIDTH +: WIDTH];
		end
	endfunction

	// ----------------------------------------
	// Global enable
	// ----------------------------------------
	// Clearing the global enable silences every port at once and leaves the
	// per-pin enables as they were, so software can pause detection cheaply.
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			global_en_q <= `PCI_GLOBAL_EN_RST;
		end
		else if (global_en_wr_in)
		begin
			global_en_q <= global_en_data_in;
		end
	end

	// ----------------------------------------
	// Edge enables
	// ----------------------------------------
	// All ports share one data word, so one write may arm the same pins on
	// several ports in the same cycle.
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rise_q <= {PORTS*WIDTH{1'b0}};
			fall_q <= {PORTS*WIDTH{1'b0}};
		end
		else
		begin
			rise_q <= upd(rise_q, rise_wr_in, wr_data_in);
			fall_q <= upd(fall_q, fall_wr_in, wr_data_in);
		end
	end

	// ----------------------------------------
	// Pull enables
	// ----------------------------------------
	// Pull-up and pull-down are separate flops, so software can set either,
	// both or neither; this block only carries the requests to the pad.
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pu_q <= {PORTS*WIDTH{1'b0}};
			pd_q <= {PORTS*WIDTH{1'b0}};
		end
		else
		begin
			pu_q <= upd(pu_q, pull_up_wr_in, wr_data_in);
			pd_q <= upd(pd_q, pull_down_wr_in, wr_data_in);
		end
	end

	// ----------------------------------------
	// Ports
	// ----------------------------------------
	// Detection runs on the free-running reference clock; this block sits in
	// the always-on domain so sleep does not stop it.
	// A pin change shows in the flags four edges after the pin moves.
	genvar g;
	generate
		for (g = 0; g < PORTS; g = g + 1)
		begin : gp
			pci_port #(
				.WIDTH(WIDTH)
			) u_port (
				.ref_clk_in             (ref_clk_in),
				.rst_b_in               (rst_b_in),
				.global_en_in           (global_en_q),
				.rising_edge_enable_in  (rise_q[g*WIDTH +: WIDTH]),
				.falling_edge_enable_in (fall_q[g*WIDTH +: WIDTH]),
				.flag_wr_in             (flag_wr_in[g]),
				.flag_wr_data_in        (wr_data_in),
				.pin_in                 (pin_in[g*WIDTH +: WIDTH]),
				.pin_change_flag_out    (flag_w[g*WIDTH +: WIDTH]),
				.pin_state_out          (pin_state_out[g*WIDTH +: WIDTH])
			);
		end
	endgenerate

	// ----------------------------------------
	// Summary and request
	// ----------------------------------------
	// The summary trails the flags by one edge. The request is taken from
	// the same next value, so summary and request always change together.
	always @*
	begin
		summary_d = {PORTS{1'b0}};
		for (i = 0; i < PORTS; i = i + 1)
		begin
			summary_d[i] = port_any(flag_w, i);
		end
	end

	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			summary_q <= {PORTS{1'b0}};
			irq_q     <= 1'b0;
		end
		else
		begin
			summary_q <= summary_d;
			irq_q     <= |summary_d;
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	// Every status output is a flop, in this module or in a port instance.
	assign change_detect_global_enable_out = global_en_q;
	assign rising_edge_enable_out          = rise_q;
	assign falling_edge_enable_out         = fall_q;
	assign pull_up_enable_out              = pu_q;
	assign pull_down_enable_out            = pd_q;
	assign pin_change_flag_out             = flag_w;
	assign port_change_summary_out         = summary_q;
	assign pin_change_interrupt_out        = irq_q;

endmodule

// [tb/pci_unit_chk_asserts.sv]
`timescale 1ns/1ps
module pci_unit_chk #(
	parameter WIDTH = 16,
	parameter PORTS = 4
)(
	input wire                   ref_clk_in,
	input wire                   rst_b_in,
	input wire                   global_en_wr_in,
	input wire                   global_en_data_in,
	input wire [PORTS-1:0]       rise_wr_in,
	input wire [PORTS-1:0]       flag_wr_in,
	input wire [WIDTH-1:0]       wr_data_in,
	input wire                   change_detect_global_enable_out,
	input wire [PORTS*WIDTH-1:0] rising_edge_enable_out,
	input wire [PORTS*WIDTH-1:0] falling_edge_enable_out,
	input wire [PORTS*WIDTH-1:0] pin_change_flag_out,
	input wire [PORTS*WIDTH-1:0] pin_state_out,
	input wire [PORTS-1:0]       port_change_summary_out,
	input wire                   pin_change_interrupt_out
);
	localparam int N = PORTS*WIDTH;
	logic [N-1:0]     f_q, s_q, r_q, e_q;
	logic [WIDTH-1:0] d_q;
	logic             g_q, w_q, rw_q;
	wire  [N-1:0]     nf = pin_change_flag_out & ~f_q;
	wire  [N-1:0]     hit = {N{g_q}} & (r_q & pin_state_out & ~s_q | e_q & ~pin_state_out & s_q);
	always @(posedge ref_clk_in)
	begin
		f_q <= pin_change_flag_out;
		s_q <= pin_state_out;
		r_q <= rising_edge_enable_out;
		e_q <= falling_edge_enable_out;
		g_q <= change_detect_global_enable_out;
		d_q <= wr_data_in;
		w_q <= flag_wr_in[0];
		rw_q <= rise_wr_in[0];
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	chk_irq_any: assert property (pin_change_interrupt_out == |port_change_summary_out)
		else $error("irq differs from summary");
	chk_set_cause: assert property ((nf & ~hit) == 0)
		else $error("flag set without enabled edge");
	chk_edge_sets: assert property ((hit & ~pin_change_flag_out) == 0)
		else $error("enabled edge not flagged");
	chk_sum_port: assert property (port_change_summary_out ==
		{|f_q[63:48], |f_q[47:32], |f_q[31:16], |f_q[15:0]})
		else $error("summary wrong");
	chk_flag_sticky: assert property (!w_q |-> (f_q[15:0] & ~pin_change_flag_out[15:0]) == 0)
		else $error("flag dropped without write");
	chk_clear_keep: assert property (w_q |-> (f_q[15:0] & d_q & ~pin_change_flag_out[15:0]) == 0)
		else $error("kept flag lost");
	chk_glob_load: assert property ($past(global_en_wr_in) |->
		change_detect_global_enable_out == $past(global_en_data_in))
		else $error("global enable not loaded");
	chk_rise_load: assert property (rw_q |-> rising_edge_enable_out[15:0] == d_q)
		else $error("rise enable not loaded");
endmodule
bind pci_unit pci_unit_chk #(.WIDTH(WIDTH), .PORTS(PORTS)) u_chk (.ref_clk_in, .rst_b_in, .global_en_wr_in,
	.global_en_data_in, .rise_wr_in, .flag_wr_in, .wr_data_in, .change_detect_global_enable_out,
	.rising_edge_enable_out, .falling_edge_enable_out, .pin_change_flag_out, .pin_state_out,
	.port_change_summary_out, .pin_change_interrupt_out);

// [tb/pci_pin_model.sv]
`timescale 1ns/1ps
module pci_pin_model (
	input  wire        ref_clk_in,
	input  wire [63:0] drive_in,
	input  wire [63:0] level_in,
	input  wire [63:0] pull_up_in,
	input  wire [63:0] pull_down_in,
	output wire [63:0] pin_out
);
	reg [63:0] float_q = 64'h0;
	// A floating pin toggles, so no settled level is ever assumed for it.
	always @(posedge ref_clk_in) float_q <= ~float_q;
	assign pin_out = drive_in & level_in | ~drive_in & (pull_up_in | ~pull_down_in & float_q);
endmodule

// [tb/pci_unit_tb_top.sv]
`timescale 1ns/1ps
module pci_unit_tb_top;
	logic        clk = 0, rst_b = 0, gwr = 0, gdat = 0;
	logic [3:0]  rwr = 0, fwr = 0, uwr = 0, dwr = 0, cwr = 0;
	logic [15:0] wd = 0;
	logic [63:0] lvl = 0, drv = '1;
	wire  [63:0] pin, pu, pd, re, fe, fl, st;
	wire  [3:0]  sm;
	wire         ge, irq;
	int          error_cnt = 0, n_checks = 0;
	initial forever #2.5 clk = ~clk;
	pci_pin_model pins (.ref_clk_in(clk), .drive_in(drv), .level_in(lvl), .pull_up_in(pu), .pull_down_in(pd),
		.pin_out(pin));
	pci_unit uut (.ref_clk_in(clk), .rst_b_in(rst_b), .global_en_wr_in(gwr), .global_en_data_in(gdat),
		.rise_wr_in(rwr), .fall_wr_in(fwr), .pull_up_wr_in(uwr), .pull_down_wr_in(dwr), .flag_wr_in(cwr),
		.wr_data_in(wd), .pin_in(pin), .pull_up_enable_out(pu), .pull_down_enable_out(pd),
		.change_detect_global_enable_out(ge), .rising_edge_enable_out(re), .falling_edge_enable_out(fe),
		.pin_change_flag_out(fl), .pin_state_out(st), .port_change_summary_out(sm),
		.pin_change_interrupt_out(irq));
	task ck(input logic [63:0] s, input logic [63:0] e, input string nm);
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Select bits: global, rise, fall, pull-up, pull-down, flag clear.
	task wr(input [5:0] s, input [3:0] p, input [15:0] d);
		@(negedge clk);
		{gwr, rwr, fwr, uwr, dwr, cwr} = {s[0], p & {4{s[1]}}, p & {4{s[2]}}, p & {4{s[3]}}, p & {4{s[4]}}, p & {4{s[5]}}};
		gdat = d[0];
		wd = d;
		@(negedge clk);
		{gwr, rwr, fwr, uwr, dwr, cwr} = 0;
	endtask
	task wirq(input logic v);
		for (int i = 0; i < 20 && irq !== v; i++)
			@(negedge clk);
		ck(irq, v, "irq_wait");
		if (irq !== v)
			stop_test();
		repeat (2) @(negedge clk);
	endtask
	task t_off;
		ck({ge, irq, sm}, 0, "reset_ctl");
		ck(fl | re | fe | pu | pd, 0, "reset_regs");
		wr(6'h06, 4'h1, 16'hffff);
		ck(re[15:0] & fe[15:0], 16'hffff, "edge_en");
		lvl[0] = 1;
		repeat (8) @(negedge clk);
		lvl[0] = 0;
		repeat (8) @(negedge clk);
		ck(fl, 0, "flags_off");
	endtask
	task t_edges;
		wr(6'h01, 4'h0, 16'h0001);
		ck(ge, 1, "global_en");
		wr(6'h02, 4'h1, 16'h0005);
		wr(6'h04, 4'h1, 16'h0006);
		lvl[2:0] = 3'h7;
		wirq(1);
		ck(fl[15:0], 16'h0005, "rise_flags");
		ck(sm, 4'h1, "sum_rise");
		wr(6'h20, 4'h1, 16'h0000);
		wirq(0);
		lvl[2:0] = 3'h0;
		wirq(1);
		ck(fl[15:0], 16'h0006, "fall_flags");
	endtask
	task t_clear;
		wr(6'h02, 4'h2, 16'h8000);
		lvl[31] = 1;
		repeat (6) @(negedge clk);
		lvl[31] = 0;
		repeat (6) @(negedge clk);
		ck(fl[31:16], 16'h8000, "sticky");
		wr(6'h20, 4'h1, 16'hfffb);
		ck(fl[15:0], 16'h0002, "mask_clear");
		@(negedge clk);
		ck(sm, 4'h3, "sum_two");
		wr(6'h20, 4'h1, 16'hfffd);
		@(negedge clk);
		ck({irq, sm}, 5'h12, "sum_one");
		wr(6'h20, 4'h2, 16'h0000);
		@(negedge clk);
		ck({irq, sm}, 5'h00, "sum_none");
	endtask
	// Clear the flags seen set: all-ones mask, exclusive-or, then and back.
	task clr(input [3:0] p, input int k);
		logic [15:0] w0;
		w0 = 16'hffff ^ fl[k*16 +: 16];
		wr(6'h20, p, w0);
	endtask
	task t_race;
		lvl[0] = 1;
		repeat (6) @(negedge clk);
		ck(fl[15:0], 16'h0001, "rise_again");
		lvl[0] = 0;
		repeat (6) @(negedge clk);
		lvl[0] = 1;
		repeat (2) @(negedge clk);
		clr(4'h1, 0);
		ck(fl[15:0], 16'h0001, "set_wins");
		clr(4'h1, 0);
		ck(fl[15:0], 16'h0000, "seq_clear");
	endtask
	task t_reset;
		lvl[31] = 1;
		repeat (6) @(negedge clk);
		ck(fl[31:16], 16'h8000, "pre_reset");
		rst_b = 0;
		@(negedge clk);
		ck({ge, irq, sm}, 0, "rerst_ctl");
		ck(fl | re | fe | pu | pd, 0, "rerst_regs");
		rst_b = 1;
		repeat (2) @(negedge clk);
	endtask
	task t_pull;
		wr(6'h08, 4'h8, 16'h0001);
		wr(6'h10, 4'h8, 16'h0002);
		ck({pu[63:48], pd[63:48]}, 32'h0001_0002, "pull_en");
		drv[49:48] = 2'h0;
		repeat (8) @(negedge clk);
		ck(st[49:48], 2'h1, "pull_level");
		ck(fl[63:48], 0, "no_enable");
		drv[49:48] = 2'h3;
		wr(6'h18, 4'h8, 16'h0000);
		ck({pu[63:48], pd[63:48]}, 0, "pull_off");
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst_b = 1;
		t_off();
		t_edges();
		t_clear();
		t_race();
		t_pull();
		t_reset();
		stop_test();
	end
endmodule
